/* File: rtl/xfer_dec_pkg.sv */
/*
  Constants for the data-transfer instruction decoder: opcode patterns,
  field positions, operation codes and execution cycle counts.
  Assumes a byte-wide prefetch stream feeding the decoder.
*/
package xfer_dec_pkg;

  // Opcode patterns
  localparam logic [7:0] OPC_SEG_TO_RM   = 8'h8C;
  localparam logic [7:0] OPC_RM_TO_SEG   = 8'h8E;
  localparam logic [7:0] OPC_GRP_FF      = 8'hFF;
  localparam logic [5:0] OPC_PUSH_IMM    = 6'h1A;  // 011010 in bits 7:2
  localparam logic [7:0] OPC_STORE_ALL   = 8'h60;
  localparam logic [6:0] OPC_SWAP        = 7'h43;  // 1000011 in bits 7:1
  localparam logic [7:0] OPC_ACC_FLAGS   = 8'h9E;
  localparam logic [2:0] OPC_POP_SEG_LO  = 3'h7;   // 111 in bits 2:0
  localparam logic [2:0] OPC_POP_SEG_HI  = 3'h0;   // 000 in bits 7:5
  localparam logic [2:0] FF_PUSH_MEM     = 3'h6;   // 110 in reg field
  localparam logic [1:0] SEG_POP_BAD     = 2'h1;   // Register 01 cannot pop
  localparam logic [1:0] MOD_REG         = 2'h3;

  // Field positions
  localparam int MOD_HI  = 7;
  localparam int MOD_LO  = 6;
  localparam int REG_HI  = 5;
  localparam int REG_LO  = 3;
  localparam int SEG_HI  = 4;
  localparam int SEG_LO  = 3;
  localparam int SEG_ZB  = 5;
  localparam int W_BIT   = 0;
  localparam int S_BIT   = 1;

  // Execution cycle counts
  localparam logic [6:0] CYC_SEG_TO_REG = 7'h02;  // 2
  localparam logic [6:0] CYC_SEG_TO_MEM = 7'h0F;  // 15
  localparam logic [6:0] CYC_REG_TO_SEG = 7'h02;  // 2
  localparam logic [6:0] CYC_MEM_TO_SEG = 7'h0D;  // 13
  localparam logic [6:0] CYC_PUSH_MEM   = 7'h14;  // 20
  localparam logic [6:0] CYC_PUSH_IMM   = 7'h0E;  // 14
  localparam logic [6:0] CYC_STORE_ALL  = 7'h44;  // 68
  localparam logic [6:0] CYC_POP_SEG    = 7'h0C;  // 12
  localparam logic [6:0] CYC_SWAP_REG   = 7'h04;  // 4
  localparam logic [6:0] CYC_SWAP_MEM   = 7'h11;  // 17
  localparam logic [6:0] CYC_ACC_FLAGS  = 7'h03;  // 3

  // Decoded operation
  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_SEG_TO_RM  = 4'h1,
    OP_RM_TO_SEG  = 4'h2,
    OP_PUSH_MEM   = 4'h3,
    OP_PUSH_IMM   = 4'h4,
    OP_STORE_ALL  = 4'h5,
    OP_POP_SEG    = 4'h6,
    OP_SWAP       = 4'h7,
    OP_ACC_FLAGS  = 4'h8,
    OP_ILLEGAL    = 4'h9
  } op_type;

endpackage

/* File: rtl/xfer_decoder.sv */
/*
  Data-transfer instruction decoder. Takes opcode bytes one per valid
  strobe, gathers the operand byte and immediate bytes, then issues one
  decoded operation with its cycle count, width and fields.
  Assumes the byte stream is synchronous to clk_i and that the execution
  unit consumes each issue pulse; the stream may pause between bytes.
*/
`timescale 1ns/100ps
// Contract
// - 8C copies segment to r/m, 2/15 clocks
// - 8E loads segment from r/m, 2/13
// - FF with reg 110 pushes memory, 20
// - 011010s0 push immediate, 14, s picks bytes
// - 60 pushes all registers, 68 clocks
// - 000 sr 111 pops segment, 12; sr 01 bad
// - 1000011w swaps reg with r/m, 4/17
// - 9E copies accumulator high byte to flags
module xfer_decoder
(
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic                byte_valid_i,
  input  wire logic [7:0]          byte_i,
  output logic                     issue_o,
  output xfer_dec_pkg::op_type     op_o,
  output logic [6:0]               cycles_o,
  output logic                     word_o,
  output logic                     mem_o,
  output logic [7:0]               modrm_o,
  output logic [15:0]              imm_o
);
  import xfer_dec_pkg::*;

  typedef enum logic [1:0] {
    ST_OPC   = 2'b00,
    ST_MODRM = 2'b01,
    ST_IMM0  = 2'b10,
    ST_IMM1  = 2'b11
  } state_type;

  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  state_type   state_ff;
  logic [7:0]  opc_ff;
  logic        issue_ff;
  op_type      op_ff;
  logic [6:0]  cyc_ff;
  logic        word_ff;
  logic        mem_ff;
  logic [7:0]  modrm_ff;
  logic [15:0] imm_ff;

  // Opcode needs an operand byte
  function automatic logic needs_modrm(input logic [7:0] b);
    return (b == OPC_SEG_TO_RM) || (b == OPC_RM_TO_SEG) ||
           (b == OPC_GRP_FF) || (b[7:1] == OPC_SWAP);
  endfunction

  // Push-immediate opcode, bit 0 fixed at zero
  function automatic logic is_push_imm(input logic [7:0] b);
    return (b[7:2] == OPC_PUSH_IMM) && !b[W_BIT];
  endfunction

  // Operand byte names a register, not memory
  function automatic logic mod_is_reg(input logic [7:0] m);
    return m[MOD_HI:MOD_LO] == MOD_REG;
  endfunction

  // Single-byte segment pop pattern
  function automatic logic is_pop_seg(input logic [7:0] b);
    return (b[7:5] == OPC_POP_SEG_HI) && (b[2:0] == OPC_POP_SEG_LO);
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Byte gathering sequence
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_OPC;
      opc_ff   <= 8'h00;
      modrm_ff <= 8'h00;
      imm_ff   <= 16'h0000;
    end else if (byte_valid_i) begin
      unique case (state_ff)
        ST_OPC: begin
          opc_ff <= byte_i;
          if (needs_modrm(byte_i)) begin
            state_ff <= ST_MODRM;
          end else if (is_push_imm(byte_i)) begin
            state_ff <= ST_IMM0;
          end
        end
        ST_MODRM: begin
          modrm_ff <= byte_i;
          state_ff <= ST_OPC;
        end
        ST_IMM0: begin
          imm_ff <= {{8{byte_i[7]}}, byte_i};
          if (opc_ff[S_BIT]) begin
            state_ff <= ST_OPC;
          end else begin
            state_ff <= ST_IMM1;
          end
        end
        ST_IMM1: begin
          imm_ff[15:8] <= byte_i;
          state_ff     <= ST_OPC;
        end
      endcase
    end
  end

  // Decode and issue one operation per complete instruction
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      issue_ff <= 1'b0;
      op_ff    <= OP_NONE;
      cyc_ff   <= 7'h00;
      word_ff  <= 1'b0;
      mem_ff   <= 1'b0;
    end else begin
      issue_ff <= 1'b0;
      if (byte_valid_i) begin
        unique case (state_ff)
          ST_OPC: begin
            if (!needs_modrm(byte_i) && !is_push_imm(byte_i)) begin
              issue_ff <= 1'b1;
              mem_ff   <= 1'b0;
              word_ff  <= 1'b1;
              if (byte_i == OPC_STORE_ALL) begin
                op_ff  <= OP_STORE_ALL;
                cyc_ff <= CYC_STORE_ALL;
              end else if (byte_i == OPC_ACC_FLAGS) begin
                op_ff   <= OP_ACC_FLAGS;
                cyc_ff  <= CYC_ACC_FLAGS;
                word_ff <= 1'b0;
              end else if (is_pop_seg(byte_i) &&
                           byte_i[SEG_HI:SEG_LO] != SEG_POP_BAD) begin
                op_ff  <= OP_POP_SEG;
                cyc_ff <= CYC_POP_SEG;
              end else begin
                op_ff  <= OP_ILLEGAL;
                cyc_ff <= 7'h00;
              end
            end
          end
          ST_MODRM: begin
            issue_ff <= 1'b1;
            mem_ff   <= !mod_is_reg(byte_i);
            word_ff  <= 1'b1;
            if (opc_ff == OPC_SEG_TO_RM && !byte_i[SEG_ZB]) begin
              op_ff  <= OP_SEG_TO_RM;
              cyc_ff <= mod_is_reg(byte_i) ?
                        CYC_SEG_TO_REG : CYC_SEG_TO_MEM;
            end else if (opc_ff == OPC_RM_TO_SEG && !byte_i[SEG_ZB]) begin
              op_ff  <= OP_RM_TO_SEG;
              cyc_ff <= mod_is_reg(byte_i) ?
                        CYC_REG_TO_SEG : CYC_MEM_TO_SEG;
            end else if (opc_ff == OPC_GRP_FF &&
                         byte_i[REG_HI:REG_LO] == FF_PUSH_MEM) begin
              op_ff  <= OP_PUSH_MEM;
              cyc_ff <= CYC_PUSH_MEM;
            end else if (opc_ff[7:1] == OPC_SWAP) begin
              op_ff   <= OP_SWAP;
              cyc_ff  <= mod_is_reg(byte_i) ?
                         CYC_SWAP_REG : CYC_SWAP_MEM;
              // width bit selects byte or word
              word_ff <= opc_ff[W_BIT];
            end else begin
              op_ff  <= OP_ILLEGAL;
              cyc_ff <= 7'h00;
            end
          end
          ST_IMM0: begin
            if (opc_ff[S_BIT]) begin
              issue_ff <= 1'b1;
              op_ff    <= OP_PUSH_IMM;
              cyc_ff   <= CYC_PUSH_IMM;
              word_ff  <= 1'b1;
              mem_ff   <= 1'b0;
            end
          end
          ST_IMM1: begin
            issue_ff <= 1'b1;
            op_ff    <= OP_PUSH_IMM;
            cyc_ff   <= CYC_PUSH_IMM;
            word_ff  <= 1'b1;
            mem_ff   <= 1'b0;
          end
        endcase
      end
    end
  end

  assign issue_o  = issue_ff;
  assign op_o     = op_ff;
  assign cycles_o = cyc_ff;
  assign word_o   = word_ff;
  assign mem_o    = mem_ff;
  assign modrm_o  = modrm_ff;
  assign imm_o    = imm_ff;

  // Checks
  sequence opc_seen(logic [7:0] v);
    byte_valid_i && state_ff == ST_OPC && byte_i == v;
  endsequence

  store_all_cyc_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    opc_seen(OPC_STORE_ALL) |=> issue_o && op_o == OP_STORE_ALL
      && cycles_o == CYC_STORE_ALL) else $error("store all count wrong");
  flags_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    opc_seen(OPC_ACC_FLAGS) |=> issue_o && op_o == OP_ACC_FLAGS)
    else $error("flags copy not issued");
  pop_seg_bad_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    opc_seen(8'h0F) |=> issue_o && op_o == OP_ILLEGAL)
    else $error("bad segment pop accepted");
  pop_seg_ok_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    opc_seen(8'h1F) |=> issue_o && op_o == OP_POP_SEG &&
      cycles_o == CYC_POP_SEG)
    else $error("segment pop wrong");
  seg_store_cyc_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    issue_o && op_o == OP_SEG_TO_RM |->
      cycles_o == (mem_o ? CYC_SEG_TO_MEM : CYC_SEG_TO_REG))
    else $error("segment store count");
  seg_load_cyc_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    issue_o && op_o == OP_RM_TO_SEG |->
      cycles_o == (mem_o ? CYC_MEM_TO_SEG : CYC_REG_TO_SEG))
    else $error("segment load count");
  push_mem_cyc_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    issue_o && op_o == OP_PUSH_MEM |-> cycles_o == CYC_PUSH_MEM
      && mem_o == (modrm_o[7:6] != MOD_REG)
      && modrm_o[5:3] == FF_PUSH_MEM) else $error("memory push wrong");
  swap_cyc_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    issue_o && op_o == OP_SWAP |->
      cycles_o == (mem_o ? CYC_SWAP_MEM : CYC_SWAP_REG))
    else $error("swap count wrong");
  swap_width_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    opc_seen(8'h86) ##1 (byte_valid_i && state_ff == ST_MODRM) |=>
      issue_o && !word_o) else $error("byte swap width");
  push_short_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    opc_seen(8'h6A) ##1 (byte_valid_i && state_ff == ST_IMM0) |=>
      issue_o && op_o == OP_PUSH_IMM && cycles_o == CYC_PUSH_IMM)
    else $error("short immediate push");

endmodule

/* File: sim/testbench.sv */
/*
  Self-checking bench for the data-transfer decoder: hand-picked and
  seeded random instructions, expected results worked out here.
  Assumes the decoder ports and op codes of xfer_dec_pkg.
*/
`timescale 1ns/100ps
module testbench;
  import xfer_dec_pkg::*;
  logic                 clk_i, nrst_i, byte_valid_i, issue_o, word_o, mem_o;
  logic [7:0]           byte_i, modrm_o;
  logic [6:0]           cycles_o, e_cyc;
  logic [15:0]          imm_o, e_imm;
  op_type               op_o, e_op;
  logic                 e_w, e_m;
  int                   e_len, error_cnt, compares, tick;
  int                   seed = 32'h1C154EC0;
  logic [7:0]           tab [14] = '{8'h8C, 8'h8E, 8'hFF, 8'h6A, 8'h68,
    8'h60, 8'h07, 8'h0F, 8'h17, 8'h1F, 8'h86, 8'h87, 8'h9E, 8'h26};

  xfer_decoder i_xfer_decoder (.clk_i(clk_i), .nrst_i(nrst_i),
    .byte_valid_i(byte_valid_i), .byte_i(byte_i), .issue_o(issue_o),
    .op_o(op_o), .cycles_o(cycles_o), .word_o(word_o), .mem_o(mem_o),
    .modrm_o(modrm_o), .imm_o(imm_o));

  // Clock, 25 ns period
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  // Hang guard
  always @(posedge clk_i) begin
    tick++;
    if (tick == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Expected decode of one instruction
  task automatic calc(input logic [7:0] b0, b1, b2);
    e_m = (b1[7:6] != 2'h3);
    e_len = 1; e_cyc = 7'h00; e_w = 1'b1; e_op = OP_ILLEGAL;
    if (b0 == 8'h8C || b0 == 8'h8E) begin
      e_len = 2;
      if (!b1[5]) begin
        e_op = b0[1] ? OP_RM_TO_SEG : OP_SEG_TO_RM;
        e_cyc = !e_m ? 7'h02 : (b0[1] ? 7'h0D : 7'h0F);
      end
    end else if (b0 == 8'hFF) begin
      e_len = 2;
      if (b1[5:3] == 3'h6) begin
        e_op = OP_PUSH_MEM; e_cyc = 7'h14;
      end
    end else if (b0[7:2] == 6'h1A && !b0[0]) begin
      e_len = b0[1] ? 2 : 3; e_op = OP_PUSH_IMM; e_cyc = 7'h0E;
      e_imm = b0[1] ? {{8{b1[7]}}, b1} : {b2, b1};
    end else if (b0 == 8'h60) begin
      e_op = OP_STORE_ALL; e_cyc = 7'h44;
    end else if (b0[7:5] == 3'h0 && b0[2:0] == 3'h7 && b0[4:3] != 2'h1) begin
      e_op = OP_POP_SEG; e_cyc = 7'h0C;
    end else if (b0[7:1] == 7'h43) begin
      e_len = 2; e_op = OP_SWAP; e_cyc = e_m ? 7'h11 : 7'h04; e_w = b0[0];
    end else if (b0 == 8'h9E) begin
      e_op = OP_ACC_FLAGS; e_cyc = 7'h03; e_w = 1'b0;
    end
  endtask

  // Send one instruction with random gaps and check the issue
  task automatic run(input logic [7:0] b0, b1, b2);
    logic [7:0] bs [3];
    int         n;
    bs[0] = b0; bs[1] = b1; bs[2] = b2;
    calc(b0, b1, b2);
    for (int k = 0; k < e_len; k++) begin
      @(negedge clk_i);
      if (($random(seed) & 3) == 0) begin
        byte_valid_i <= 1'b0;
        @(negedge clk_i);
      end
      byte_valid_i <= 1'b1;
      byte_i <= bs[k];
    end
    @(negedge clk_i);
    byte_valid_i <= 1'b0;
    byte_i <= 8'($random(seed));
    n = 0;
    while (issue_o !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    chk("issue", 16'(issue_o), 16'h0001);
    chk("op", 16'(op_o), 16'(e_op));
    chk("cycles", 16'(cycles_o), 16'(e_cyc));
    if (e_op != OP_ILLEGAL) chk("word", 16'(word_o), 16'(e_w));
    if (e_op == OP_PUSH_IMM) chk("imm", imm_o, e_imm);
    if (e_op != OP_ILLEGAL && e_len == 2 && e_op != OP_PUSH_IMM) begin
      chk("mem", 16'(mem_o), 16'(e_m));
      chk("modrm", 16'(modrm_o), 16'(b1));
    end
    @(negedge clk_i);
    chk("pulse", 16'(issue_o), 16'h0000);
    chk("hold", 16'(op_o), 16'(e_op));
  endtask

  task automatic do_reset();
    nrst_i <= 1'b0;
    byte_valid_i <= 1'b0;
    repeat (10) @(negedge clk_i);
    chk("rst_op", 16'(op_o), 16'(OP_NONE));
    chk("rst_issue", 16'(issue_o), 16'h0000);
    chk("rst_cycles", 16'(cycles_o), 16'h0000);
    nrst_i <= 1'b1;
    repeat (4) @(negedge clk_i);
  endtask

  // Main sequence
  initial begin
    logic [31:0] r;
    nrst_i = 1'b0; byte_valid_i = 1'b0; byte_i = 8'h00;
    error_cnt = 0; compares = 0; tick = 0;
    do_reset();
    run(8'h60, 8'h00, 8'h00); run(8'h8C, 8'hC0, 8'h00);
    run(8'h8C, 8'h06, 8'h00); run(8'h8C, 8'h20, 8'h00);
    run(8'h8E, 8'hD8, 8'h00); run(8'h8E, 8'h1E, 8'h00);
    run(8'hFF, 8'h36, 8'h00); run(8'hFF, 8'h06, 8'h00);
    run(8'h6A, 8'h80, 8'h00); run(8'h68, 8'h34, 8'h12);
    run(8'h07, 8'h00, 8'h00); run(8'h0F, 8'h00, 8'h00);
    run(8'h17, 8'h00, 8'h00); run(8'h1F, 8'h00, 8'h00);
    run(8'h86, 8'hC1, 8'h00); run(8'h87, 8'h07, 8'h00);
    run(8'h9E, 8'h00, 8'h00);
    // Reset in mid-instruction, then a clean decode
    @(negedge clk_i);
    byte_valid_i <= 1'b1;
    byte_i <= 8'h8C;
    @(negedge clk_i);
    do_reset();
    run(8'h60, 8'h00, 8'h00);
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      run((r[3:0] < 4'hE) ? tab[r[3:0]] : r[15:8], r[23:16], r[31:24]);
    end
    complete_run();
  end
endmodule
